// file: psio_pkg.sv
package psio_pkg;

   localparam int LANES   = 8;
   localparam int BYTE_W  = 8;
   localparam int DATA_W  = LANES * BYTE_W;
   localparam int ADDR_W  = 20;
   localparam int BURST_W = 2;
   localparam int BUF_DEPTH = 2;

   // level taken by the burst-order strap when it floats
   localparam logic STRAP_DEFAULT = 1'b1;
   // edges after reset release before the synchronised strap is trusted
   localparam logic [1:0] STRAP_SETTLE = 2'h2;
   // output-enable pin level that means tri-state
   localparam logic OE_OFF = 1'b1;

   typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE} psio_op_t;

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic [LANES-1:0]  parityIo;
   } psio_word_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [LANES-1:0]  laneEn;
      psio_word_t        word;
   } psio_wr_req_t;

   function automatic logic psio_selected(input logic firstN, input logic second, input logic thirdN);
      psio_selected = !firstN && second && !thirdN;
   endfunction

   // each lane enable covers its byte and its own parity bit
   function automatic psio_word_t psio_lane_mask(input logic [LANES-1:0] laneEn);
      psio_word_t m;
      m = '0;
      for (int i = 0; i < LANES; i++) begin
         m.data[i*BYTE_W +: BYTE_W] = {BYTE_W{laneEn[i]}};
         m.parityIo[i] = laneEn[i];
      end
      psio_lane_mask = m;
   endfunction

endpackage

// file: psio_two_buf.sv
`timescale 1ns/1ps
module psio_two_buf #(
   parameter int W = 8
) (
   input  wire logic         sys_clk,
   input  wire logic         reset_n,
   input  wire logic         inValid,
   output logic             inReady,
   input  wire logic [W-1:0] inData,
   output logic             outValid,
   input  wire logic         outReady,
   output logic [W-1:0]     outData
);
   import psio_pkg::*;

   logic [W-1:0] memReg [BUF_DEPTH];
   logic         wrIdxReg;
   logic         rdIdxReg;
   logic [1:0]   countReg;
   logic         push;
   logic         pop;

   assign inReady  = countReg != 2'(BUF_DEPTH);
   assign outValid = countReg != 2'h0;
   assign outData  = memReg[rdIdxReg];
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;

   always_ff @(posedge sys_clk) begin
      if (push) begin
         memReg[wrIdxReg] <= inData;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         wrIdxReg <= 1'b0;
         rdIdxReg <= 1'b0;
         countReg <= 2'h0;
      end else begin
         if (push) begin
            wrIdxReg <= !wrIdxReg;
         end
         if (pop) begin
            rdIdxReg <= !rdIdxReg;
         end
         countReg <= countReg + 2'(push) - 2'(pop);
      end
   end

   chk_buf_bound: assert property (@(posedge sys_clk) disable iff (!reset_n)
      countReg <= 2'(BUF_DEPTH))
      else $error("buffer count above depth");

endmodule

// file: psio_burst_seq.sv
`timescale 1ns/1ps
module psio_burst_seq #(
   parameter int W = 2
) (
   input  wire logic         sys_clk,
   input  wire logic         reset_n,
   input  wire logic         load,
   input  wire logic         step,
   input  wire logic         interleaved,
   input  wire logic [W-1:0] base,
   output logic [W-1:0]     low
);
   import psio_pkg::*;

   logic [W-1:0] baseReg;
   logic [W-1:0] cntReg;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         baseReg <= '0;
         cntReg  <= '0;
      end else if (load) begin
         baseReg <= base;
         cntReg  <= '0;
      end else if (step) begin
         cntReg <= cntReg + W'(1);
      end
   end

   // wraps within the burst group
   assign low = interleaved ? (baseReg ^ cntReg) : W'(baseReg + cntReg);

endmodule

// file: psio_io_ctrl.sv
`timescale 1ns/1ps
module psio_io_ctrl (
   input  wire logic                       sys_clk,
   input  wire logic                       reset_n,
   input  wire logic                       clockQualifyN,
   input  wire logic                       chipSelectFirstN,
   input  wire logic                       chipSelectSecond,
   input  wire logic                       chipSelectThirdN,
   input  wire logic                       advanceOrLoad,
   input  wire logic                       writeRequestN,
   input  wire logic [psio_pkg::LANES-1:0] byteLaneWriteN,
   input  wire logic [psio_pkg::ADDR_W-1:0] address,
   input  wire logic                       outputEnableN,
   input  wire logic                       burstOrderStrap,
   input  wire psio_pkg::psio_word_t       dataIoIn,
   output psio_pkg::psio_word_t            dataIoOut,
   output logic                            dataIoOeN,
   output logic [psio_pkg::ADDR_W-1:0]     coreAddr,
   input  wire psio_pkg::psio_word_t       coreRdData,
   output logic                            coreWrValid,
   input  wire logic                       coreWrReady,
   output logic [psio_pkg::ADDR_W-1:0]     coreWrAddr,
   output psio_pkg::psio_word_t            coreWrWord,
   output psio_pkg::psio_word_t            coreWrMask,
   output logic                            writeReady
);
   import psio_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // declarations

   logic          qual;
   logic          selected;
   logic          loadTake;
   logic          burstAdv;
   logic          driveEn;
   logic          writeMask;
   logic [BURST_W-1:0] burstLow;

   psio_op_t      opReg;
   psio_op_t      outOpReg;
   logic [ADDR_W-1:0] addrReg;
   logic [LANES-1:0]  laneEnReg;
   psio_word_t    outWordReg;

   psio_wr_req_t  capReg;
   logic          capValidReg;
   logic          bufInReady;
   psio_wr_req_t  bufOut;

   logic          oeMetaReg;
   logic          oeSyncReg;
   logic          strapMetaReg;
   logic          strapSyncReg;
   logic [1:0]    strapCntReg;
   logic          strapTakenReg;
   logic          modeReg;

   ////////////////////////////////////////////////////////////////////////
   // qualification and command decode

   assign qual     = !clockQualifyN;
   assign selected = psio_selected(chipSelectFirstN, chipSelectSecond, chipSelectThirdN);
   assign loadTake = qual && !advanceOrLoad;
   assign burstAdv = qual && advanceOrLoad && (opReg != OP_IDLE);

   ////////////////////////////////////////////////////////////////////////
   // asynchronous output enable, two flops

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         oeMetaReg <= OE_OFF;
         oeSyncReg <= OE_OFF;
      end else begin
         oeMetaReg <= outputEnableN;
         oeSyncReg <= oeMetaReg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // burst-order strap, synchronised then frozen

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         strapMetaReg <= STRAP_DEFAULT;
         strapSyncReg <= STRAP_DEFAULT;
      end else begin
         strapMetaReg <= burstOrderStrap;
         strapSyncReg <= strapMetaReg;
      end
   end

   // taken once; a later change is not followed
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         strapCntReg   <= 2'h0;
         strapTakenReg <= 1'b0;
         modeReg       <= STRAP_DEFAULT;
      end else if (!strapTakenReg) begin
         if (strapCntReg == STRAP_SETTLE) begin
            strapTakenReg <= 1'b1;
            modeReg       <= strapSyncReg;
         end else begin
            strapCntReg <= strapCntReg + 2'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // operation pipeline

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         opReg <= OP_IDLE;
      end else if (loadTake) begin
         if (!selected) begin
            opReg <= OP_IDLE;
         end else if (writeRequestN) begin
            opReg <= OP_READ;
         end else begin
            opReg <= OP_WRITE;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         addrReg   <= '0;
         laneEnReg <= '0;
      end else if (loadTake && selected) begin
         addrReg   <= address;
         laneEnReg <= ~byteLaneWriteN;
      end
   end

   // only a qualified edge moves the stage; deselect is never forced
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         outOpReg <= OP_IDLE;
      end else if (qual) begin
         outOpReg <= opReg;
      end
   end

   psio_burst_seq #(
      .W (BURST_W)
   ) u_burst (
      .sys_clk     (sys_clk),
      .reset_n     (reset_n),
      .load        (loadTake && selected),
      .step        (burstAdv),
      .interleaved (modeReg),
      .base        (address[BURST_W-1:0]),
      .low         (burstLow)
   );

   assign coreAddr = {addrReg[ADDR_W-1:BURST_W], burstLow};

   ////////////////////////////////////////////////////////////////////////
   // read path and pin direction

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         outWordReg <= '0;
      end else if (qual && (opReg == OP_READ)) begin
         outWordReg <= coreRdData;
      end
   end

   assign writeMask = opReg == OP_WRITE;
   // idle output stage covers deselect and the first clock out of it
   assign driveEn   = (outOpReg == OP_READ) && !writeMask && (oeSyncReg != OE_OFF);
   assign dataIoOeN = !driveEn;
   assign dataIoOut = outWordReg;

   ////////////////////////////////////////////////////////////////////////
   // write capture and buffer

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         capReg <= '0;
      end else if (qual && writeMask) begin
         capReg.addr   <= coreAddr;
         capReg.laneEn <= laneEnReg;
         capReg.word   <= dataIoIn;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         capValidReg <= 1'b0;
      end else if (qual && writeMask) begin
         capValidReg <= 1'b1;
      end else if (bufInReady) begin
         capValidReg <= 1'b0;
      end
   end

   psio_two_buf #(
      .W ($bits(psio_wr_req_t))
   ) u_wbuf (
      .sys_clk  (sys_clk),
      .reset_n  (reset_n),
      .inValid  (capValidReg),
      .inReady  (bufInReady),
      .inData   (capReg),
      .outValid (coreWrValid),
      .outReady (coreWrReady),
      .outData  (bufOut)
   );

   assign writeReady = bufInReady;
   assign coreWrAddr = bufOut.addr;
   assign coreWrWord = bufOut.word;
   assign coreWrMask = psio_lane_mask(bufOut.laneEn);

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   chk_drive_read_out: assert property (
      (qual && opReg == OP_READ) ##1 (opReg != OP_WRITE && oeSyncReg != OE_OFF) |-> !dataIoOeN)
      else $error("read data not driven with output enable low");

   chk_float_oe_high: assert property (
      oeSyncReg == OE_OFF |-> dataIoOeN)
      else $error("pins driven while output enable high");

   chk_mask_write_desel: assert property (
      (opReg == OP_WRITE || outOpReg == OP_IDLE) |-> dataIoOeN)
      else $error("pins driven during write data or deselect");

   chk_hold_unqualified: assert property (
      clockQualifyN |=> $stable(opReg) && $stable(outOpReg) && $stable(addrReg)
                        && $stable(capReg) && $stable(outWordReg))
      else $error("state moved on an unqualified edge");

   chk_stretch_read: assert property (
      clockQualifyN && outOpReg == OP_READ |=> outOpReg == OP_READ && $stable(dataIoOut))
      else $error("held clock changed the read output");

   chk_capture_write: assert property (
      qual && opReg == OP_WRITE |=> capValidReg && capReg.word == $past(dataIoIn)
                                    && capReg.laneEn == $past(laneEnReg))
      else $error("write data or lanes not captured");

   chk_read_latency: assert property (
      qual && opReg == OP_READ |=> dataIoOut == $past(coreRdData))
      else $error("read data not one stage after address");

   chk_burst_interleave: assert property (
      (loadTake && selected && modeReg && address[1:0] == 2'h1) ##1 burstAdv |=> burstLow == 2'h0)
      else $error("interleaved burst order wrong");

   chk_burst_linear: assert property (
      (loadTake && selected && !modeReg && address[1:0] == 2'h1) ##1 burstAdv |=> burstLow == 2'h2)
      else $error("linear burst order wrong");

   chk_strap_default: assert property (
      !strapTakenReg |-> modeReg == STRAP_DEFAULT)
      else $error("strap default not high");

   chk_lane_select: assert property (
      loadTake && selected && !writeRequestN |=> laneEnReg == ~$past(byteLaneWriteN))
      else $error("byte lane selects not sampled with write");

   chk_idle_floats: assert property (
      qual && opReg == OP_IDLE |=> dataIoOeN)
      else $error("pins driven in first clock out of deselect");

   chk_strap_frozen: assert property (
      strapTakenReg |=> strapTakenReg && $stable(modeReg))
      else $error("burst order changed after capture");

   chk_wbuf_holds: assert property (
      coreWrValid && !coreWrReady |=> coreWrValid && $stable(coreWrAddr) && $stable(coreWrWord))
      else $error("write entry moved before it was taken");

   chk_lane_parity: assert property (
      coreWrValid |-> coreWrMask.data[BYTE_W-1:0] == {BYTE_W{coreWrMask.parityIo[0]}})
      else $error("parity bit not gated with its byte");

   cov_read: cover property (qual && opReg == OP_READ ##1 !dataIoOeN);
   cov_write: cover property (qual && opReg == OP_WRITE ##1 coreWrValid);
   cov_stall: cover property (clockQualifyN && outOpReg == OP_READ ##1 clockQualifyN);
   cov_backpressure: cover property (capValidReg && !bufInReady);
   cov_burst: cover property (burstAdv ##1 burstAdv ##1 burstAdv);

endmodule

// file: psio_ctl_model.sv
`timescale 1ns/1ps
module psio_ctl_model (
   input  wire logic                        sys_clk,
   output logic                             clockQualifyN,
   output logic                             chipSelectFirstN,
   output logic                             chipSelectSecond,
   output logic                             chipSelectThirdN,
   output logic                             advanceOrLoad,
   output logic                             writeRequestN,
   output logic [psio_pkg::LANES-1:0]       byteLaneWriteN,
   output logic [psio_pkg::ADDR_W-1:0]      address,
   output logic                             outputEnableN,
   output psio_pkg::psio_word_t             dataIoIn,
   input  wire psio_pkg::psio_word_t        dataIoOut,
   input  wire logic                        dataIoOeN
);
   import psio_pkg::*;
   logic       drvEn;
   psio_word_t wrWord;
   ////////////////////////////////////////////////////////////
   // released bus shows the inverse of the device's last word
   assign dataIoIn = drvEn ? wrWord : (dataIoOeN ? psio_word_t'(~dataIoOut) : dataIoOut);
   initial begin
      clockQualifyN = 1'b0;
      chipSelectFirstN = 1'b1;
      chipSelectSecond = 1'b0;
      chipSelectThirdN = 1'b1;
      advanceOrLoad = 1'b0;
      writeRequestN = 1'b1;
      byteLaneWriteN = '1;
      address = '0;
      outputEnableN = 1'b0;
      drvEn = 1'b0;
      wrWord = '0;
   end
   ////////////////////////////////////////////////////////////
   // one bus beat, launched just after an edge
   task automatic beat(input logic q, input logic sel, input logic adv, input logic wrN,
                       input logic [LANES-1:0] lanes, input logic [ADDR_W-1:0] a,
                       input logic drv, input psio_word_t w);
      @(posedge sys_clk);
      clockQualifyN <= q;
      chipSelectFirstN <= !sel;
      chipSelectSecond <= sel;
      chipSelectThirdN <= !sel;
      advanceOrLoad <= adv;
      writeRequestN <= wrN;
      byteLaneWriteN <= lanes;
      address <= a;
      drvEn <= drv;
      wrWord <= w;
   endtask
   task automatic idle();
      beat(1'b0, 1'b0, 1'b0, 1'b1, '1, '0, 1'b0, '0);
   endtask
   task automatic setOe(input logic v);
      @(posedge sys_clk);
      outputEnableN <= v;
   endtask
endmodule

// file: psio_tb.sv
`timescale 1ns/1ps
module tb;
   import psio_pkg::*;
   logic                sys_clk, reset_n, coreWrReady, strapDrv, strapLvl;
   tri1                 burstOrderStrap;
   logic                clockQualifyN, chipSelectFirstN, chipSelectSecond, chipSelectThirdN;
   logic                advanceOrLoad, writeRequestN, outputEnableN, dataIoOeN, coreWrValid, writeReady;
   logic [LANES-1:0]    byteLaneWriteN;
   logic [ADDR_W-1:0]   address, coreAddr, coreWrAddr;
   psio_word_t          dataIoIn, dataIoOut, coreRdData, coreWrWord, coreWrMask;
   int                  errorCnt, checks;
   ////////////////////////////////////////////////////////////
   assign burstOrderStrap = strapDrv ? strapLvl : 1'bz;
   function automatic psio_word_t memFn(input logic [ADDR_W-1:0] a);
      memFn = {8'h5C, a, ~a, a, 4'h3};
   endfunction
   assign coreRdData = memFn(coreAddr);
   psio_ctl_model mdl (.sys_clk(sys_clk), .clockQualifyN(clockQualifyN), .chipSelectFirstN(chipSelectFirstN),
      .chipSelectSecond(chipSelectSecond), .chipSelectThirdN(chipSelectThirdN), .advanceOrLoad(advanceOrLoad),
      .writeRequestN(writeRequestN), .byteLaneWriteN(byteLaneWriteN), .address(address),
      .outputEnableN(outputEnableN), .dataIoIn(dataIoIn), .dataIoOut(dataIoOut), .dataIoOeN(dataIoOeN));
   psio_io_ctrl psio_io_ctrl_i (.sys_clk(sys_clk), .reset_n(reset_n), .clockQualifyN(clockQualifyN),
      .chipSelectFirstN(chipSelectFirstN), .chipSelectSecond(chipSelectSecond),
      .chipSelectThirdN(chipSelectThirdN), .advanceOrLoad(advanceOrLoad), .writeRequestN(writeRequestN),
      .byteLaneWriteN(byteLaneWriteN), .address(address), .outputEnableN(outputEnableN),
      .burstOrderStrap(burstOrderStrap), .dataIoIn(dataIoIn), .dataIoOut(dataIoOut), .dataIoOeN(dataIoOeN),
      .coreAddr(coreAddr), .coreRdData(coreRdData), .coreWrValid(coreWrValid), .coreWrReady(coreWrReady),
      .coreWrAddr(coreWrAddr), .coreWrWord(coreWrWord), .coreWrMask(coreWrMask), .writeReady(writeReady));
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////////////////////////
   task automatic results();
      if (errorCnt == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic cmpW(input psio_word_t got, input psio_word_t exp);
      checks++;
      if (got !== exp) begin
         errorCnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmpV(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] exp);
      checks++;
      if (got !== exp) begin
         errorCnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic waitV();
      int n;
      n = 0;
      while (coreWrValid !== 1'b1 && n < 20) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      if (coreWrValid !== 1'b1) begin
         errorCnt++;
         results();
      end
   endtask
   task automatic doReset(input logic drv, input logic lvl);
      @(posedge sys_clk);
      reset_n <= 1'b0;
      strapDrv <= drv;
      strapLvl <= lvl;
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
   endtask
   ////////////////////////////////////////////////////////////
   task automatic scRead(input logic [ADDR_W-1:0] a, input logic oe);
      mdl.setOe(oe);
      mdl.idle();
      mdl.idle();
      mdl.beat(1'b0, 1'b1, 1'b0, 1'b1, '1, a, 1'b0, '0);
      mdl.idle();
      @(posedge sys_clk);
      #1;
      if (oe === 1'b0) cmpW(dataIoOut, memFn(a));
      cmpV(20'(dataIoOeN), 20'(oe));
      @(posedge sys_clk);
      #1;
      cmpV(20'(dataIoOeN), 20'h1);
   endtask
   task automatic scStall(input logic [ADDR_W-1:0] a);
      mdl.beat(1'b0, 1'b1, 1'b0, 1'b1, '1, a, 1'b0, '0);
      mdl.idle();
      // a read load offered while the clock is not qualified
      mdl.beat(1'b1, 1'b1, 1'b0, 1'b1, '1, ~a, 1'b0, '0);
      repeat (4) begin
         @(posedge sys_clk);
         #1;
         cmpW(dataIoOut, memFn(a));
         cmpV(20'(dataIoOeN), 20'h0);
      end
      mdl.idle();
      @(posedge sys_clk);
      #1;
      cmpV(20'(dataIoOeN), 20'h1);
   endtask
   task automatic scWrite(input logic [ADDR_W-1:0] a, input logic [LANES-1:0] ln, input psio_word_t w);
      psio_word_t mk;
      for (int i = 0; i < LANES; i++) begin
         mk.data[i*BYTE_W +: BYTE_W] = {BYTE_W{!ln[i]}};
         mk.parityIo[i] = !ln[i];
      end
      // a read just before, so the write data phase must mask a driving stage
      mdl.beat(1'b0, 1'b1, 1'b0, 1'b1, '1, a ^ 20'h1, 1'b0, '0);
      mdl.beat(1'b0, 1'b1, 1'b0, 1'b0, ln, a, 1'b0, '0);
      mdl.beat(1'b0, 1'b0, 1'b0, 1'b1, '1, '0, 1'b1, w);
      #1;
      cmpV(20'(dataIoOeN), 20'h1);
      mdl.idle();
      waitV();
      cmpV(coreWrAddr, a);
      cmpW(coreWrWord, w);
      cmpW(coreWrMask, mk);
   endtask
   task automatic scFill();
      @(posedge sys_clk);
      coreWrReady <= 1'b0;
      mdl.beat(1'b0, 1'b1, 1'b0, 1'b0, '0, 20'h00100, 1'b0, '0);
      mdl.beat(1'b0, 1'b1, 1'b0, 1'b0, '0, 20'h00200, 1'b1, memFn(20'h1));
      mdl.beat(1'b0, 1'b0, 1'b0, 1'b1, '1, '0, 1'b1, memFn(20'h2));
      mdl.idle();
      repeat (2) @(posedge sys_clk);
      #1;
      cmpV(20'(writeReady), 20'h0);
      @(posedge sys_clk);
      coreWrReady <= 1'b1;
      #1;
      cmpV(coreWrAddr, 20'h00100);
      @(posedge sys_clk);
      #1;
      cmpV(coreWrAddr, 20'h00200);
      cmpW(coreWrWord, memFn(20'h2));
      @(posedge sys_clk);
      #1;
      cmpV(20'({coreWrValid, writeReady}), 20'h1);
   endtask
   task automatic scBurst(input logic drv, input logic lvl, input logic [7:0] exp);
      doReset(drv, lvl);
      mdl.beat(1'b0, 1'b1, 1'b0, 1'b1, '1, 20'h00041, 1'b0, '0);
      for (int i = 0; i < 4; i++) begin
         mdl.beat(1'b0, 1'b1, 1'b1, 1'b1, '1, '0, 1'b0, '0);
         #1;
         cmpV(coreAddr, {18'h00010, exp[2*i +: 2]});
      end
      mdl.idle();
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      reset_n = 1'b0;
      coreWrReady = 1'b1;
      strapDrv = 1'b0;
      strapLvl = 1'b0;
      errorCnt = 0;
      checks = 0;
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      scRead(20'hABCDE, 1'b1);
      scRead(20'h12345, 1'b0);
      scStall(20'h0F0F0);
      scWrite(20'h54321, 8'hA5, memFn(20'h00777));
      scFill();
      scBurst(1'b0, 1'b0, 8'hB1);
      scBurst(1'b1, 1'b0, 8'h39);
      results();
   end
endmodule
